// File: hdl/dpc_ctrl_end.sv
// Memory controller end: divided link clock, commands, burst data
`default_nettype none
module dpc_ctrl_end
    import dpc_pkg::*;
(
    // Clock, reset, freeze
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire dpc_cmd_e req_cmd,
    input wire logic [BA_W-1:0] req_ba,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [BURST_W-1:0] req_wdata,
    input wire logic [MASK_W-1:0] req_wmask,
    // Pin levels
    input wire logic cke_req,
    input wire logic odt_req,
    // Answer
    output logic rsp_valid,
    output logic rsp_err,
    output logic [BURST_W-1:0] rsp_rdata,
    // Link
    dpc_link_if.ctrl link
);
    typedef enum logic {C_IDLE, C_BURST} dpc_cst_e;
    typedef struct packed {
        dpc_cst_e st;
        logic [1:0] ph;
        logic ck;
        logic cke;
        logic rstn;
        logic [3:0] code;
        logic odt;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] a;
        logic [LANES-1:0] dm;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic dqs;
        logic ready;
        logic rvalid;
        logic err;
        dpc_cmd_e kind;
        logic [3:0] beat;
        logic [3:0] nb;
        logic [BANKS-1:0] open;
        logic [BURST_W-1:0] wdata;
        logic [MASK_W-1:0] wmask;
        logic [BURST_W-1:0] rdata;
    } dpc_ctl_s;

    dpc_ctl_s q;
    dpc_ctl_s n;

    always_comb begin
        n = q;
        n.rvalid = 1'b0;
        n.err = 1'b0;
        if (ce) begin
            n.ph = q.ph + 2'h1;
            n.ck = ~n.ph[1];
            // Levels move only where the link clock holds still
            if (q.ph == PH_FALL) begin
                n.cke = cke_req;
                n.odt = odt_req;
                n.rstn = 1'b1;
            end
            case (q.st)
                C_IDLE: begin
                    if (req_valid && q.ready) begin
                        n.kind = req_cmd;
                        n.ba = req_ba;
                        n.a = req_addr;
                        n.wdata = req_wdata;
                        n.wmask = req_wmask;
                        n.beat = 4'h0;
                        n.nb = req_addr[BC_BIT] ? BEATS_BL8 : BEATS_BC4;
                        n.st = C_BURST;
                        case (req_cmd)
                            CMD_ACT: begin
                                n.code = CODE_ACT;
                                n.open[req_ba] = 1'b1;
                            end
                            CMD_PRE: begin
                                n.code = CODE_PRE;
                                if (req_addr[AP_BIT]) begin
                                    n.open = '0;
                                end else begin
                                    n.open[req_ba] = 1'b0;
                                end
                            end
                            CMD_RD,
                            CMD_WR: begin
                                n.code = (req_cmd == CMD_RD) ? CODE_RD
                                                             : CODE_WR;
                                if (req_addr[AP_BIT]) begin
                                    n.open[req_ba] = 1'b0;
                                end
                                // Idle bank: refuse, nothing on the pins
                                if (!q.open[req_ba]) begin
                                    n = q;
                                    n.ph = q.ph + 2'h1;
                                    n.ck = ~n.ph[1];
                                    n.err = 1'b1;
                                end
                            end
                            CMD_MRS: n.code = CODE_MRS;
                            default: n.code = CODE_NOP;
                        endcase
                    end
                end
                C_BURST: begin
                    case (q.ph)
                        PH_RISE: begin
                            n.code = CODE_DES;
                            if (q.kind != CMD_RD && q.kind != CMD_WR) begin
                                n.st = C_IDLE;
                            end else if (q.kind == CMD_WR) begin
                                if (q.beat == q.nb) begin
                                    n.dq_oe = 1'b0;
                                    n.st = C_IDLE;
                                end else begin
                                    n.dq_oe = 1'b1;
                                    n.dq = q.wdata[q.beat[2:0]*DQ_W +: DQ_W];
                                    n.dm = q.wmask[q.beat[2:0]*LANES +: LANES];
                                    n.beat = q.beat + 4'h1;
                                end
                            end
                        end
                        PH_TAKE: begin
                            // Strobe edge in mid data eye
                            if (q.dq_oe) begin
                                n.dqs = 1'b1;
                            end
                            if (q.kind == CMD_RD && q.code == CODE_DES) begin
                                n.rdata[q.beat[2:0]*DQ_W +: DQ_W] = link.dq;
                                n.beat = q.beat + 4'h1;
                            end
                        end
                        PH_FALL: begin
                            if (q.dq_oe) begin
                                n.dq = q.wdata[q.beat[2:0]*DQ_W +: DQ_W];
                                n.dm = q.wmask[q.beat[2:0]*LANES +: LANES];
                                n.beat = q.beat + 4'h1;
                            end
                        end
                        default: begin
                            n.dqs = 1'b0;
                            if (q.kind == CMD_RD && q.code == CODE_DES) begin
                                n.rdata[q.beat[2:0]*DQ_W +: DQ_W] = link.dq;
                                n.beat = q.beat + 4'h1;
                                if (q.beat + 4'h1 == q.nb) begin
                                    n.rvalid = 1'b1;
                                    n.st = C_IDLE;
                                end
                            end
                        end
                    endcase
                end
                default: n.st = C_IDLE;
            endcase
            n.ready = (n.st == C_IDLE) && (n.ph == PH_TAKE);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
            q.code <= CODE_DES;
        end else begin
            q <= n;
        end
    end

    assign link.ck = q.ck;
    assign link.ck_n = ~q.ck;
    assign link.cke = q.cke;
    assign link.reset_n = q.rstn;
    assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = q.code;
    assign link.odt = q.odt;
    assign link.ba = q.ba;
    assign link.a = q.a;
    assign link.dm = q.dm;
    assign link.dq_c = q.dq;
    assign link.dq_c_oe = q.dq_oe;
    assign link.dqs_c = {LANES{q.dqs}};
    assign req_ready = q.ready;
    assign rsp_valid = q.rvalid;
    assign rsp_err = q.err;
    assign rsp_rdata = q.rdata;
endmodule
`default_nettype wire

// File: hdl/dpc_dram_end.sv
// DRAM device end: command decode, banks, burst data, termination
`default_nettype none
module dpc_dram_end
    import dpc_pkg::*;
(
    // Link
    dpc_link_if.dev link,
    // Device status
    output logic [BANKS-1:0] bank_active,
    output logic term_on,
    output logic chop_last
);
    typedef struct packed {
        logic [BANKS-1:0] act;
        logic [BANKS-1:0][1:0] pc;
        logic [BANKS-1:0][ADDR_W-1:0] row;
        logic [ADDR_W-1:0] mr1;
        logic [ADDR_W-1:0] mr2;
        logic term;
        logic rd;
        logic wr;
        logic [1:0] left;
        logic [BA_W-1:0] bank;
        logic [1:0] pair;
        logic ap;
        logic chop;
        logic [2*DQ_W-1:0] rd_pair;
        logic [MEM_WORDS-1:0][DQ_W-1:0] mem;
    } dpc_dev_s;

    dpc_dev_s q;
    dpc_dev_s n;
    logic [DQ_W-1:0] even_q;
    logic [LANES-1:0] even_dm_q;
    logic [3:0] code;
    logic [COL_W-1:0] col;
    logic rtt_en;

    assign code = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    assign col = link.a[COL_W-1:0];
    assign rtt_en = (|(q.mr1 & RTT_NOM_MASK)) |
                    (|(q.mr2 & RTT_WR_MASK));

    // First beat of each write pair lands on the falling CK edge
    always_ff @(negedge link.ck or negedge link.reset_n) begin
        if (!link.reset_n) begin
            even_q <= '0;
            even_dm_q <= '0;
        end else if (link.cke) begin
            even_q <= link.dq;
            even_dm_q <= link.dm;
        end
    end

    always_comb begin
        n = q;
        // Frozen cycle: nothing moves, not even burst progress
        if (link.cke) begin
            // Registered ODT gated by termination setting
            n.term = link.odt & rtt_en;

            for (int b = 0; b < BANKS; b++) begin
                if (q.pc[b] != 2'h0) begin
                    n.pc[b] = q.pc[b] - 2'h1;
                    if (q.pc[b] == 2'h1) begin
                        n.act[b] = 1'b0;
                    end
                end
            end

            // Write pair: falling-edge beat plus rising-edge beat
            if (q.wr) begin
                for (int l = 0; l < LANES; l++) begin
                    if (!even_dm_q[l]) begin
                        n.mem[{q.bank, q.pair, 1'b0}][l*LANE_W +: LANE_W] =
                            even_q[l*LANE_W +: LANE_W];
                    end
                    if (!link.dm[l]) begin
                        n.mem[{q.bank, q.pair, 1'b1}][l*LANE_W +: LANE_W] =
                            link.dq[l*LANE_W +: LANE_W];
                    end
                end
            end

            if (q.rd || q.wr) begin
                if (q.left == 2'h0) begin
                    n.rd = 1'b0;
                    n.wr = 1'b0;
                    if (q.ap) begin
                        n.pc[q.bank] = PRE_CK;
                    end
                end else begin
                    n.left = q.left - 2'h1;
                    n.pair = q.pair + 2'h1;
                    n.rd_pair = {n.mem[{q.bank, n.pair, 1'b1}],
                                 n.mem[{q.bank, n.pair, 1'b0}]};
                end
            end

            // Chip select high: decoder disabled
            if (!link.cs_n) begin
                case (code)
                    CODE_ACT: begin
                        n.act[link.ba] = 1'b1;
                        n.pc[link.ba] = 2'h0;
                        n.row[link.ba] = link.a;
                    end
                    CODE_PRE: begin
                        if (link.a[AP_BIT]) begin
                            for (int b = 0; b < BANKS; b++) begin
                                if (q.act[b]) begin
                                    n.pc[b] = PRE_CK;
                                end
                            end
                        end else if (q.act[link.ba]) begin
                            n.pc[link.ba] = PRE_CK;
                        end
                    end
                    CODE_RD,
                    CODE_WR: begin
                        n.rd = link.we_n;
                        n.wr = !link.we_n;
                        n.bank = link.ba;
                        n.pair = col[2:1];
                        n.ap = link.a[AP_BIT];
                        n.chop = !link.a[BC_BIT];
                        n.left = link.a[BC_BIT] ? PAIRS_BL8 : PAIRS_BC4;
                        n.rd_pair = {q.mem[{link.ba, col[2:1], 1'b1}],
                                     q.mem[{link.ba, col[2:1], 1'b0}]};
                    end
                    CODE_MRS: begin
                        if (link.ba == MR1_BA) begin
                            n.mr1 = link.a;
                        end else if (link.ba == MR2_BA) begin
                            n.mr2 = link.a;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Link clock may stop in reset, so reset is asynchronous
    always_ff @(posedge link.ck or negedge link.reset_n) begin
        if (!link.reset_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Read data rides both CK halves, strobe edge-aligned
    assign link.dq_d = link.ck ? q.rd_pair[DQ_W-1:0]
                               : q.rd_pair[2*DQ_W-1:DQ_W];
    assign link.dq_d_oe = q.rd;
    assign link.dqs_d = {LANES{link.ck & q.rd}};

    assign bank_active = q.act;
    assign term_on = q.term;
    assign chop_last = q.chop;
endmodule
`default_nettype wire

// File: hdl/dpc_link_if.sv
// Pin-level link between memory controller and DRAM device
`default_nettype none
interface dpc_link_if;
    import dpc_pkg::*;
    logic ck;
    logic ck_n;
    logic cke;
    logic reset_n;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0] dm;
    logic [DQ_W-1:0] dq_c;
    logic dq_c_oe;
    logic [LANES-1:0] dqs_c;
    logic [DQ_W-1:0] dq_d;
    logic dq_d_oe;
    logic [LANES-1:0] dqs_d;
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] dqs;
    logic [LANES-1:0] dqs_n;
    // Wire level from the two drivers; undriven bus reads low
    assign dq = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : '0);
    assign dqs = dq_c_oe ? dqs_c : (dq_d_oe ? dqs_d : '0);
    assign dqs_n = ~dqs;
    modport ctrl (
        output ck, ck_n, cke, reset_n, cs_n, ras_n, cas_n, we_n,
        output odt, ba, a, dm, dq_c, dq_c_oe, dqs_c,
        input dq, dqs, dqs_n
    );
    modport dev (
        input ck, ck_n, cke, reset_n, cs_n, ras_n, cas_n, we_n,
        input odt, ba, a, dm, dq, dqs, dqs_n,
        output dq_d, dq_d_oe, dqs_d
    );
endinterface
`default_nettype wire

// File: hdl/dpc_pkg.sv
// Shared constants and types for both ends of the DDR3 pin link
`default_nettype none
// Operation
// - Activate carries row; read/write carries column
// - Mode register set takes opcode from address
// - A10 high on access means auto-precharge
// - Precharge: A10 low one bank, high all
// - A12 low chops burst, high full burst
// - Chip select high masks every command
// - Commands latched only on rising CK edge
// - RAS low, CAS high, WE high: activate
// - RAS low, CAS high, WE low: precharge
// - RAS high, CAS low: WE selects read/write
// - One strobe pair per byte lane
// - Device strobes reads; controller strobes writes
// - Mask high discards that lane's write byte
// - Data moves on both strobe edges
// - Registered ODT high enables data termination
// - ODT ignored when mode registers disable termination
// - Reset low holds device asynchronously
// - Clock enable low freezes device state
// - Bank address picks the target bank
package dpc_pkg;
    localparam int BA_W = 3;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int BANKS = 8;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int BEATS = 8;
    localparam int BURST_W = BEATS * DQ_W;
    localparam int MASK_W = BEATS * LANES;
    localparam int MEM_WORDS = 64;
    // Pairs left after the first one of a burst, and beats per burst
    localparam logic [1:0] PAIRS_BL8 = 2'h3;
    localparam logic [1:0] PAIRS_BC4 = 2'h1;
    localparam logic [3:0] BEATS_BL8 = 4'h8;
    localparam logic [3:0] BEATS_BC4 = 4'h4;
    // Link clock cycles a bank spends precharging
    localparam logic [1:0] PRE_CK = 2'h2;
    // Controller phase of the divided link clock
    localparam logic [1:0] PH_TAKE = 2'h1;
    localparam logic [1:0] PH_RISE = 2'h0;
    localparam logic [1:0] PH_FALL = 2'h2;
    localparam logic [1:0] PH_LATE = 2'h3;
    // Mode register bank codes and termination fields
    localparam logic [2:0] MR1_BA = 3'h1;
    localparam logic [2:0] MR2_BA = 3'h2;
    localparam logic [12:0] RTT_NOM_MASK = 13'h0244;
    localparam logic [12:0] RTT_WR_MASK = 13'h0600;
    // Pin codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CODE_MRS = 4'h0;
    localparam logic [3:0] CODE_PRE = 4'h2;
    localparam logic [3:0] CODE_ACT = 4'h3;
    localparam logic [3:0] CODE_WR = 4'h4;
    localparam logic [3:0] CODE_RD = 4'h5;
    localparam logic [3:0] CODE_NOP = 4'h7;
    localparam logic [3:0] CODE_DES = 4'hF;
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACT,
        CMD_PRE,
        CMD_RD,
        CMD_WR,
        CMD_MRS
    } dpc_cmd_e;
endpackage
`default_nettype wire

// File: sim/dpc_link_props.sv
// Assertions on the pin link between controller and device ends
`default_nettype none
module dpc_link_props import dpc_pkg::*; (
    // Clocks and resets
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ck,
    input wire logic reset_n,
    // Link pins
    input wire logic ck_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] a,
    input wire logic dq_c_oe,
    input wire logic dq_d_oe,
    input wire logic [LANES-1:0] dqs,
    input wire logic [LANES-1:0] dqs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] code;
    assign code = {cs_n, ras_n, cas_n, we_n};
    // Pins settling on the rising link clock would race the device
    a_ck_pair: assert property (
        @(posedge sys_clk) disable iff (rst)
        ck_n == ~ck && (!$rose(ck) || $stable({code, cke, a, reset_n})))
        else $error("pins moved at rising link clock");
    a_strobe_diff: assert property (
        @(posedge sys_clk) disable iff (rst) dqs_n == ~dqs)
        else $error("strobe pair not complementary");
    a_one_driver: assert property (
        @(posedge sys_clk) disable iff (rst) !(dq_c_oe && dq_d_oe))
        else $error("both ends drive data");
    a_rst_quiet: assert property (
        @(posedge sys_clk) disable iff (rst)
        !reset_n |-> !dq_d_oe && !dq_c_oe) else $error("drive in reset");
    // Read strobe must follow the link clock while the device drives
    a_read_strobe: assert property (
        @(posedge sys_clk) disable iff (rst)
        (dq_d_oe && !dq_c_oe) |-> dqs == {LANES{ck}})
        else $error("read strobe not edge aligned");
    a_rd_chop: assert property (@(posedge ck) disable iff (!reset_n)
        (cke && code == CODE_RD && !a[BC_BIT]) |=>
        dq_d_oe ##1 dq_d_oe ##1 !dq_d_oe) else $error("chopped read length");
    a_rd_full: assert property (@(posedge ck) disable iff (!reset_n)
        (cke && code == CODE_RD && a[BC_BIT]) |=>
        dq_d_oe [*4] ##1 !dq_d_oe) else $error("full read length");
    a_wr_ctrl: assert property (@(posedge ck) disable iff (!reset_n)
        (cke && code == CODE_WR) |=> dq_c_oe && !dq_d_oe)
        else $error("write data not from controller");
    a_cs_ignore: assert property (
        @(posedge ck) disable iff (!reset_n)
        (cke && cs_n && !dq_d_oe) |=> !dq_d_oe)
        else $error("deselected device drove data");
    a_cke_freeze: assert property (
        @(posedge ck) disable iff (!reset_n)
        !cke |=> $stable(dq_d_oe)) else $error("output changed while frozen");
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench joining the controller and device ends
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %0h got %0h", nm, (e), (g)); \
    end end
module tb import dpc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, ce = 1, req_valid = 0, req_ready;
    logic cke_req = 1, odt_req = 0, mask_on = 0;
    dpc_cmd_e req_cmd = CMD_NOP, c;
    logic [BA_W-1:0] req_ba = '0;
    logic [ADDR_W-1:0] req_addr = '0, ad, mr1_m = '0, mr2_m = '0;
    logic [BURST_W-1:0] req_wdata = '0, rsp_rdata;
    logic [MASK_W-1:0] req_wmask = '0;
    logic rsp_valid, rsp_err, term_on, chop_last, tx;
    logic [BANKS-1:0] bank_active, open_m = '0, open_x;
    logic [31:0] lfsr = 32'h5D356944, r;
    logic [DQ_W-1:0] mem_m [MEM_WORDS] = '{default: '0};
    int err_count = 0, tests_run = 0;
    int mb [5] = '{1, 1, 2, 2, 1};
    int mv [5] = '{'h40, 0, 'h400, 0, 'h200};
    logic mo [5] = '{0, 1, 1, 1, 1};
    dpc_link_if link ();
    dpc_ctrl_end u_dpc_ctrl_end (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
        .req_ba(req_ba), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_wmask(req_wmask), .cke_req(cke_req), .odt_req(odt_req),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
        .link(link.ctrl));
    dpc_dram_end u_dpc_dram_end (.link(link.dev), .bank_active(bank_active),
        .term_on(term_on), .chop_last(chop_last));
    dpc_link_props u_dpc_link_props (.sys_clk(sys_clk), .rst(rst),
        .ck(link.ck), .reset_n(link.reset_n), .ck_n(link.ck_n),
        .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .a(link.a),
        .dq_c_oe(link.dq_c_oe), .dq_d_oe(link.dq_d_oe), .dqs(link.dqs),
        .dqs_n(link.dqs_n));
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One request, then its answer and the model update
    task automatic op(input dpc_cmd_e cm, input int b,
                      input logic [ADDR_W-1:0] aa);
        logic [BURST_W-1:0] wd, ex, mk;
        logic [MASK_W-1:0] wm;
        logic ok, er, vs;
        int nb, ix, n;
        wd = {rnd(), rnd(), rnd(), rnd()};
        wm = mask_on ? MASK_W'(rnd()) : '0;
        ok = open_m[b];
        nb = aa[BC_BIT] ? 8 : 4;
        mk = ~({BURST_W{1'b1}} << (nb * DQ_W));
        ex = '0;
        er = 1'b0;
        vs = 1'b0;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_cmd = cm;
        req_ba = BA_W'(b);
        req_addr = aa;
        req_wdata = wd;
        req_wmask = wm;
        for (n = 0; req_ready !== 1'b1 && n < 100; n++) @(negedge sys_clk);
        if (n == 100) err_count++;
        @(negedge sys_clk);
        req_valid = 1'b0;
        // Refusal pulse lands in the first cycle checked; loop runs on to rsp_valid
        for (n = 0; n < 24 && !vs; n++) begin
            er |= (rsp_err === 1'b1);
            vs = (rsp_valid === 1'b1);
            if (!vs) @(negedge sys_clk);
        end
        `CHK("refused", (cm == CMD_RD || cm == CMD_WR) && !ok, er)
        `CHK("done", cm == CMD_RD && ok, vs)
        if (ok && (cm == CMD_RD || cm == CMD_WR)) begin
            for (int k = 0; k < nb; k++) begin
                ix = b * 8 + ((aa[2:1] + k / 2) % 4) * 2 + k % 2;
                for (int l = 0; l < LANES; l++)
                    if (cm == CMD_WR && !wm[LANES * k + l])
                        mem_m[ix][LANE_W*l +: LANE_W] =
                            wd[DQ_W*k + LANE_W*l +: LANE_W];
                ex[DQ_W*k +: DQ_W] = mem_m[ix];
            end
            if (cm == CMD_RD) begin
                `CHK("rdata", ex, rsp_rdata & mk)
                `CHK("latency", 2 * nb + 3, n)
            end
            `CHK("chop", !aa[BC_BIT], chop_last)
            if (aa[AP_BIT]) open_m[b] = 1'b0;
        end
        if (cm == CMD_ACT) open_m[b] = 1'b1;
        if (cm == CMD_PRE)
            open_m = aa[AP_BIT] ? '0 : open_m & ~(BANKS'(1) << b);
        if (cm == CMD_MRS && b == MR1_BA) mr1_m = aa;
        if (cm == CMD_MRS && b == MR2_BA) mr2_m = aa;
        // Covers the precharge delay after the last data pair
        repeat (16) @(negedge sys_clk);
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK("banks", 8'h00, bank_active)
        `CHK("term", 1'b0, term_on)
        op(CMD_RD, 3, 13'h1000);
        op(CMD_WR, 5, 13'h1000);
        for (int b = 0; b < BANKS; b++) begin
            op(CMD_ACT, b, ADDR_W'(rnd()));
            op(CMD_WR, b, 13'h1000);
        end
        `CHK("banks", open_m, bank_active)
        mask_on = 1'b1;
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            ad = ADDR_W'(rnd());
            ad[AP_BIT] = r[4] & r[5];
            ad[BC_BIT] = r[6];
            c = !open_m[r[2:0]] ? (r[3] ? CMD_ACT : CMD_RD) :
                r[9:7] == 3'h0 ? CMD_PRE : r[7] ? CMD_RD : CMD_WR;
            op(c, r[2:0], ad);
            `CHK("banks", open_m, bank_active)
        end
        op(CMD_ACT, 6, 13'h0000);
        open_x = open_m;
        cke_req = 1'b0;
        op(CMD_PRE, 0, 13'h0400);
        cke_req = 1'b1;
        `CHK("frozen", open_x, bank_active)
        op(CMD_PRE, 0, 13'h0400);
        `CHK("banks", open_m, bank_active)
        for (int i = 0; i < 5; i++) begin
            odt_req = mo[i];
            op(CMD_MRS, mb[i], ADDR_W'(mv[i]));
            tx = (mr1_m & RTT_NOM_MASK) != 0 ||
                 (mr2_m & RTT_WR_MASK) != 0;
            `CHK("term", odt_req && tx, term_on)
        end
        end_of_test();
    end
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
